// ==== adc_serial_readout_timing.sv ====
// serial readout side of a sigma-delta converter: ready signalling and
// result shift-out on the shared data/ready pin
// assumes cs_n and sclk come from an outside host and are resampled here
`timescale 1ns/100ps
module adc_serial_readout_timing
    import adc_readout_pkg::*;
#(
    parameter int GAP_FULL = GAP_FULL_CYC,
    parameter int GAP_MID  = GAP_MID_CYC,
    parameter int GAP_LOW  = GAP_LOW_CYC,
    parameter int RESULT_W = RESULT_W_DEF
) (
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic                cs_n,
    input  wire logic                sclk,
    input  wire logic [1:0]          power_mode,
    input  wire logic                cont_read_mode,
    input  wire logic                hold_until_deselect,
    input  wire logic                ready_switch_delay_extend,
    input  wire logic                result_valid,
    input  wire logic [RESULT_W-1:0] result_data,
    output logic                     dout,
    output logic                     dout_oe,
    output logic                     data_ready,
    output logic                     read_done
);

    // ****************************************
    // pin resampling
    // ****************************************
    logic [PIN_N-1:0] pin_in;
    logic [PIN_N-1:0] lvl_r;
    logic [PIN_N-1:0] lvl_d_r;
    logic [2:0]       sync_r [PIN_N];

    // reset levels match the idle pins, so no false edge after reset
    assign pin_in = {cs_n, sclk};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_N; gi++) begin : g_sync
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    sync_r[gi]  <= {3{PIN_RST[gi]}};
                    lvl_r[gi]   <= PIN_RST[gi];
                    lvl_d_r[gi] <= PIN_RST[gi];
                end else begin
                    sync_r[gi]  <= {sync_r[gi][1:0], pin_in[gi]};
                    // a change counts once stages two and three agree
                    if (sync_r[gi][2] == sync_r[gi][1]) begin
                        lvl_r[gi] <= sync_r[gi][2];
                    end
                    lvl_d_r[gi] <= lvl_r[gi];
                end
            end
        end
    endgenerate

    logic sclk_fall;
    logic sclk_rise;
    logic cs_act;

    assign sclk_fall = lvl_d_r[PIN_SCLK] & ~lvl_r[PIN_SCLK];
    assign sclk_rise = ~lvl_d_r[PIN_SCLK] & lvl_r[PIN_SCLK];
    assign cs_act    = ~lvl_r[PIN_CS];

    // ****************************************
    // result holding and ready indication
    // ****************************************
    logic [RESULT_W-1:0]  result_r;
    logic                 ready_r;
    logic                 fresh_r;
    logic [GAP_CNT_W-1:0] gap_cnt_r;
    logic [GAP_CNT_W-1:0] gap_len;
    logic                 read_end;

    always_comb begin
        case (power_mode)
            PWR_MID: gap_len = GAP_CNT_W'(GAP_MID);
            PWR_LOW: gap_len = GAP_CNT_W'(GAP_LOW);
            default: gap_len = GAP_CNT_W'(GAP_FULL);
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            result_r  <= '0;
            ready_r   <= 1'b0;
            fresh_r   <= 1'b0;
            gap_cnt_r <= '0;
        end else begin
            // a new result wins over a read ending in the same cycle
            if (result_valid) begin
                result_r <= result_data;
                fresh_r  <= 1'b1;
                if (ready_r) begin
                    // RL3: high gap first
                    ready_r   <= 1'b0;
                    gap_cnt_r <= gap_len;
                end else begin
                    ready_r   <= 1'b1;
                    gap_cnt_r <= '0;
                end
            end else begin
                if (read_end) begin
                    // RL5: ready returns high
                    ready_r <= 1'b0;
                    fresh_r <= 1'b0;
                end
                if (gap_cnt_r != '0) begin
                    gap_cnt_r <= gap_cnt_r - GAP_CNT_W'(1);
                    if (gap_cnt_r == GAP_CNT_W'(1)) begin
                        ready_r <= 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            data_ready <= 1'b0;
        end else begin
            // one cycle behind ready_r so the port comes from a flop
            data_ready <= ready_r;
        end
    end

    // ****************************************
    // shift-out sequencer
    // ****************************************
    localparam int BIT_W = $clog2(RESULT_W);

    rd_state_t            state_r;
    logic [RESULT_W-1:0]  shift_r;
    logic [BIT_W-1:0]     bit_cnt_r;
    logic [DLY_CNT_W-1:0] dly_cnt_r;
    logic                 can_read;

    // RL6: re-read allowed
    // RL7: one shot when continuous
    assign can_read = cont_read_mode ? fresh_r : 1'b1;
    // a deselect landing with the last rise aborts rather than completes
    assign read_end = (state_r == ST_SHIFT) && sclk_rise && cs_act &&
                      (bit_cnt_r == '0);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r   <= ST_IDLE;
            shift_r   <= '0;
            bit_cnt_r <= '0;
            dly_cnt_r <= '0;
            dout      <= 1'b1;
            dout_oe   <= 1'b0;
            read_done <= 1'b0;
        end else begin
            read_done <= 1'b0;
            if (!cs_act) begin
                // RL11: release on deselect
                state_r <= ST_IDLE;
                dout_oe <= 1'b0;
                dout    <= 1'b1;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        state_r <= ST_SEL;
                        dout_oe <= 1'b1;
                        dout    <= ~ready_r;
                    end
                    ST_SEL: begin
                        dout <= ~ready_r;
                        if (sclk_fall && can_read) begin
                            // RL4: data on falling edge
                            shift_r   <= result_r << 1;
                            dout      <= result_r[RESULT_W-1];
                            bit_cnt_r <= BIT_W'(RESULT_W - 1);
                            state_r   <= ST_SHIFT;
                        end
                    end
                    ST_SHIFT: begin
                        if (sclk_fall && bit_cnt_r != '0) begin
                            // RL4: next bit on falling edge
                            dout      <= shift_r[RESULT_W-1];
                            shift_r   <= shift_r << 1;
                            bit_cnt_r <= bit_cnt_r - BIT_W'(1);
                        end else if (read_end) begin
                            read_done <= 1'b1;
                            if (hold_until_deselect) begin
                                // RL9: keep lsb until deselect
                                state_r <= ST_HOLD;
                            end else begin
                                // RL10: switch delay
                                state_r   <= ST_TAIL;
                                dly_cnt_r <= ready_switch_delay_extend ?
                                             DLY_CNT_W'(RDY_SW_EXT_CYC) :
                                             DLY_CNT_W'(RDY_SW_CYC);
                            end
                        end
                    end
                    // counted from the detected rise, which trails the pin,
                    // so the minimum delay holds with margin
                    ST_TAIL: begin
                        dly_cnt_r <= dly_cnt_r - DLY_CNT_W'(1);
                        if (dly_cnt_r == DLY_CNT_W'(1)) begin
                            // RL8: pin turns to ready
                            dout    <= ~ready_r;
                            state_r <= ST_SEL;
                        end
                    end
                    ST_HOLD: begin
                        state_r <= ST_HOLD;
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

// ==== adc_readout_pkg.sv ====
// constants shared by the serial readout block of the converter
// assumes a 250 MHz system clock sampling all serial pins
//
// Contract
// RL1: host idles 3, 12 or 24 master clocks between serial operations.
// RL2: host holds restart low 3, 12 or 24 master clocks by power mode.
// RL3: a result landing while ready is low gives 6, 25 or 50 us high first.
// RL4: data changes on the falling serial clock edge, sampled on the rise.
// RL5: once the host has read a result the ready indication returns high.
// RL6: outside continuous read a result may be re-read while ready is high.
// RL7: in continuous read mode each result is shifted out once only.
// RL8: hold-until-deselect clear: pin turns to ready after the last rise.
// RL9: hold-until-deselect set: lsb stays on the pin until deselect.
// RL10: the switch to ready waits at least 10 ns, or 110 ns when extended.
// RL11: after chip select goes high the output is released within 80 ns.
package adc_readout_pkg;

    localparam int RESULT_W_DEF   = 24;
    localparam int CLK_PERIOD_NS  = 4;

    // ready switch delay after the last rising serial clock edge
    localparam int T_RDY_SW_NS     = 10;
    localparam int T_RDY_SW_EXT_NS = 110;
    localparam int RDY_SW_CYC      =
        (T_RDY_SW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RDY_SW_EXT_CYC  =
        (T_RDY_SW_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // typical high time when a result lands while ready is shown
    localparam int T_GAP_FULL_US  = 6;
    localparam int T_GAP_MID_US   = 25;
    localparam int T_GAP_LOW_US   = 50;
    localparam int GAP_FULL_CYC   = T_GAP_FULL_US * 1000 / CLK_PERIOD_NS;
    localparam int GAP_MID_CYC    = T_GAP_MID_US * 1000 / CLK_PERIOD_NS;
    localparam int GAP_LOW_CYC    = T_GAP_LOW_US * 1000 / CLK_PERIOD_NS;
    localparam int GAP_CNT_W      = 16;
    localparam int DLY_CNT_W      = 8;

    // power mode encoding
    localparam logic [1:0] PWR_FULL = 2'h0;
    localparam logic [1:0] PWR_MID  = 2'h1;
    localparam logic [1:0] PWR_LOW  = 2'h2;

    // pin synchroniser slots and their reset levels
    localparam int         PIN_SCLK = 0;
    localparam int         PIN_CS   = 1;
    localparam int         PIN_N    = 2;
    localparam logic [1:0] PIN_RST  = 2'h3;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_SEL   = 5'b00010,
        ST_SHIFT = 5'b00100,
        ST_TAIL  = 5'b01000,
        ST_HOLD  = 5'b10000
    } rd_state_t;

endpackage

// ==== adc_readout_checker_asserts.sv ====
// port checker for the serial readout block
// assumes the block's own ports only; bound at the foot of the file
`timescale 1ns/100ps
module adc_readout_checker
    import adc_readout_pkg::*;
#(
    parameter int GAP_FULL = GAP_FULL_CYC,
    parameter int GAP_MID  = GAP_MID_CYC,
    parameter int GAP_LOW  = GAP_LOW_CYC,
    parameter int RESULT_W = RESULT_W_DEF
) (
    input wire logic                clk_sys,
    input wire logic                rst,
    input wire logic                cs_n,
    input wire logic                sclk,
    input wire logic [1:0]          power_mode,
    input wire logic                cont_read_mode,
    input wire logic                hold_until_deselect,
    input wire logic                ready_switch_delay_extend,
    input wire logic                result_valid,
    input wire logic [RESULT_W-1:0] result_data,
    input wire logic                dout,
    input wire logic                dout_oe,
    input wire logic                data_ready,
    input wire logic                read_done
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ************************************************
    // gap length tracking
    // ************************************************
    logic                 gap_on_r;
    logic [GAP_CNT_W-1:0] low_cnt_r;
    logic [GAP_CNT_W-1:0] gap_exp;
    assign gap_exp = (power_mode == PWR_MID) ? GAP_CNT_W'(GAP_MID) :
                     (power_mode == PWR_LOW) ? GAP_CNT_W'(GAP_LOW) :
                                               GAP_CNT_W'(GAP_FULL);
    // counts low samples of ready after a result lands on a shown ready
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gap_on_r  <= 1'b0;
            low_cnt_r <= '0;
        end else if (result_valid) begin
            gap_on_r  <= data_ready && !read_done;
            low_cnt_r <= '0;
        end else if (data_ready) begin
            low_cnt_r <= '0;
            if (low_cnt_r != '0) begin
                gap_on_r <= 1'b0;
            end
        end else begin
            low_cnt_r <= low_cnt_r + GAP_CNT_W'(1);
        end
    end
    // ************************************************
    // port relations
    // ************************************************
    sequence s_ready_drop;
        ##2 (!data_ready) [*8];
    endsequence
    a_gap_full: assert property (
        (result_valid && data_ready && !read_done && power_mode == PWR_FULL)
        |-> s_ready_drop)
        else $error("ready gap wrong");
    a_gap_len: assert property (
        ($rose(data_ready) && gap_on_r) |-> low_cnt_r == gap_exp)
        else $error("ready gap length wrong");
    a_ready_rise: assert property (
        (result_valid && !data_ready) |-> ##2 data_ready)
        else $error("ready did not rise");
    a_done_clears: assert property (
        read_done |-> ##[1:2] !data_ready)
        else $error("ready kept after read");
    a_cont_once: assert property (
        (read_done && cont_read_mode) |-> data_ready)
        else $error("stale word read in continuous mode");
    a_switch_fast: assert property (
        (read_done && !hold_until_deselect && !ready_switch_delay_extend)
        |-> ##[2:4] dout)
        else $error("pin not switched to ready");
    a_switch_slow: assert property (
        (read_done && !hold_until_deselect && ready_switch_delay_extend)
        |-> $stable(dout) [*8] ##[15:25] dout)
        else $error("extended ready switch wrong");
    a_hold_lsb: assert property (
        (read_done && hold_until_deselect && !cs_n) |=> $stable(dout) [*8])
        else $error("lsb not held");
    a_oe_release: assert property (
        $rose(cs_n) |-> ##[1:20] !dout_oe)
        else $error("pin not released");
endmodule
bind adc_serial_readout_timing adc_readout_checker #(
    .GAP_FULL(GAP_FULL), .GAP_MID(GAP_MID),
    .GAP_LOW(GAP_LOW), .RESULT_W(RESULT_W)
) i_chk (
    .clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .sclk(sclk),
    .power_mode(power_mode), .cont_read_mode(cont_read_mode),
    .hold_until_deselect(hold_until_deselect),
    .ready_switch_delay_extend(ready_switch_delay_extend),
    .result_valid(result_valid), .result_data(result_data),
    .dout(dout), .dout_oe(dout_oe), .data_ready(data_ready),
    .read_done(read_done)
);

// ==== spi_host_model.sv ====
// host side of the serial readout link
// assumes the bench resolves the shared pin level into pin
`timescale 1ns/100ps
module spi_host_model #(
    parameter int MCLK_NS = 100
) (
    input  wire logic       pin,
    input  wire logic [1:0] power_mode,
    output logic            cs_n,
    output logic            sclk,
    output logic            restart_n
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        restart_n = 1'b1;
    end
    // master clock span for the current power mode
    function automatic int mclk_span();
        return (power_mode == 2'h0 ? 3 : power_mode == 2'h1 ? 12 : 24) *
               MCLK_NS;
    endfunction
    // ************************************************
    // one framed transfer of nb bits
    // ************************************************
    task automatic xfer(input int nb, output logic [23:0] w);
        w = '0;
        cs_n = 1'b0;
        #125;
        for (int i = 0; i < nb; i++) begin
            sclk = 1'b0;
            #62.5;
            sclk = 1'b1;
            w = {w[22:0], pin};
            #62.5;
        end
        #250;
        cs_n = 1'b1;
        #(mclk_span());
    endtask
    task automatic restart();
        restart_n = 1'b0;
        #(mclk_span());
        restart_n = 1'b1;
    endtask
endmodule

// ==== adc_serial_readout_timing_tb_top.sv ====
// self-checking bench for the serial readout block
// assumes the host model and the bound checker are compiled before it
`timescale 1ns/100ps
module adc_serial_readout_timing_tb_top;
    import adc_readout_pkg::*;
    localparam int G [3] = '{20, 40, 60};
    logic clk_sys, rst, cs_n, sclk, cont_read_mode, hold_until_deselect;
    logic ready_switch_delay_extend, result_valid, dout, dout_oe;
    logic data_ready, read_done, pin_last, pin_w;
    logic [1:0]  power_mode;
    logic [23:0] result_data, d, w;
    int          miscompares, checked, cnt;
    initial clk_sys = 1'b0;
    always #2 clk_sys = ~clk_sys;
    // released pin shows the inverse of its last level
    always @(posedge clk_sys) if (dout_oe) pin_last <= dout;
    assign pin_w = dout_oe ? dout : ~pin_last;
    adc_serial_readout_timing #(
        .GAP_FULL(20), .GAP_MID(40), .GAP_LOW(60), .RESULT_W(24)
    ) i_dut (
        .clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .sclk(sclk),
        .power_mode(power_mode), .cont_read_mode(cont_read_mode),
        .hold_until_deselect(hold_until_deselect),
        .ready_switch_delay_extend(ready_switch_delay_extend),
        .result_valid(result_valid), .result_data(result_data),
        .dout(dout), .dout_oe(dout_oe), .data_ready(data_ready),
        .read_done(read_done)
    );
    spi_host_model i_host (
        .pin(pin_w), .power_mode(power_mode), .cs_n(cs_n), .sclk(sclk),
        .restart_n()
    );
    // ************************************************
    // shared tasks
    // ************************************************
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (miscompares == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // cycles from the end of put until ready shows again after a gap
    function automatic int exp_gap(input int m);
        return G[m % 3] - 2;
    endfunction
    task automatic put(input logic [23:0] v);
        @(negedge clk_sys);
        result_data = v;
        result_valid = 1'b1;
        @(negedge clk_sys);
        result_valid = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask
    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        rst = 1'b1;
        power_mode = 2'h0;
        cont_read_mode = 1'b0;
        hold_until_deselect = 1'b0;
        ready_switch_delay_extend = 1'b0;
        result_valid = 1'b0;
        result_data = 24'h0;
        pin_last = 1'b0;
        miscompares = 0;
        checked = 0;
        void'($urandom(32'h27f92207));
        repeat (20) @(negedge clk_sys);
        rst = 1'b0;
        i_host.restart();
        for (int i = 0; i < 6; i++) begin
            @(negedge clk_sys);
            power_mode = 2'(i % 3);
            {ready_switch_delay_extend, hold_until_deselect} = 2'(i);
            d = 24'($urandom);
            put(d);
            chk(24'(data_ready), 24'h1);
            i_host.xfer(8, w);
            chk(24'(data_ready), 24'h1);
            i_host.xfer(24, w);
            chk(w, d);
            chk(24'(data_ready), 24'h0);
            i_host.xfer(24, w);
            chk(w, d);
            put(d ^ 24'h5a5a5a);
            put(d);
            chk(24'(data_ready), 24'h0);
            cnt = 0;
            while (data_ready !== 1'b1 && cnt < 200) begin
                @(negedge clk_sys);
                cnt++;
            end
            chk(24'(cnt), 24'(exp_gap(i)));
            i_host.xfer(24, w);
            chk(w, d);
        end
        @(negedge clk_sys);
        cont_read_mode = 1'b1;
        d = 24'($urandom);
        put(d);
        i_host.xfer(24, w);
        chk(w, d);
        i_host.xfer(24, w);
        chk(w, 24'hffffff);
        results();
    end
    // about three times the expected run length
    initial begin
        #300000;
        miscompares++;
        results();
    end
endmodule
